// >>> design/ltd_decoder.sv
module ltd_decoder (
    input wire logic clk,
    input wire logic reset,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic pc_change,
    input wire logic [7:0] pm_rdata,
    input wire logic rmw_req,
    input wire logic rmw_src_is_port,
    input wire logic [7:0] port_pins,
    input wire logic [7:0] port_latch,
    input wire logic tz_write,
    input wire logic presc_assigned,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata_r,
    output logic busy_r,
    output logic pm_rd_r,
    output logic pm_wr_r,
    output logic [20:0] pm_addr_r,
    output logic [7:0] pm_wdata_r,
    output logic ret_pop_r,
    output logic presc_clr_r,
    output logic [7:0] rmw_operand_r,
    output logic [7:0] work_r,
    output logic [4:0] status_r,
    output logic [3:0] bank_r,
    output logic [20:0] tptr_r,
    output logic [7:0] latch_r
);
    ltd_pkg::ltd_state_t s_r;
    ltd_pkg::ltd_state_t s_nxt;

    logic [7:0] op_hi;
    logic [7:0] lit;
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] logic_res;
    logic [ltd_pkg::TP_W-1:0] tp_inc;
    logic [ltd_pkg::TP_W-1:0] tp_dec;
    logic [4:0] sel_idx;

    ////////////////////////////////////////////////////////////////
    // Datapath helpers
    assign op_hi = instr_word[15:8];
    assign lit = instr_word[7:0];
    assign tp_inc = s_r.tptr + 21'h000001;
    assign tp_dec = s_r.tptr - 21'h000001;
    assign sel_idx = 5'(reg_addr - ltd_pkg::OFS_FSP_BASE);

    ////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        s_nxt = s_r;
        sum = 9'h000;
        nib = 5'h00;
        logic_res = 8'h00;
        s_nxt.pm_rd = 1'b0;
        s_nxt.pm_wr = 1'b0;
        s_nxt.ret_pop = 1'b0;
        s_nxt.presc_clr = tz_write & presc_assigned;
        s_nxt.pins_s1 = port_pins;
        s_nxt.pins_s2 = s_r.pins_s1;
        if (rmw_req) begin
            s_nxt.rmw_operand = rmw_src_is_port ? s_r.pins_s2 : port_latch;
        end

        // Bus write, instruction results below take precedence
        if (reg_wr) begin
            unique case (reg_addr)
                ltd_pkg::OFS_WORK: s_nxt.work = reg_wdata;
                ltd_pkg::OFS_STATUS: s_nxt.status = reg_wdata[4:0];
                ltd_pkg::OFS_BANK: s_nxt.bank = reg_wdata[3:0];
                ltd_pkg::OFS_TP_L: s_nxt.tptr[7:0] = reg_wdata;
                ltd_pkg::OFS_TP_H: s_nxt.tptr[15:8] = reg_wdata;
                ltd_pkg::OFS_TP_U: s_nxt.tptr[20:16] = reg_wdata[4:0];
                ltd_pkg::OFS_LATCH: s_nxt.latch = reg_wdata;
                ltd_pkg::OFS_PROD_L: s_nxt.prod[7:0] = reg_wdata;
                ltd_pkg::OFS_PROD_H: s_nxt.prod[15:8] = reg_wdata;
                default: begin
                    if (sel_idx < 5'(2 * ltd_pkg::FSP_N)) begin
                        if (sel_idx[0]) begin
                            s_nxt.fsp[sel_idx[4:1]][11:8] = reg_wdata[3:0];
                        end else begin
                            s_nxt.fsp[sel_idx[4:1]][7:0] = reg_wdata;
                        end
                    end
                end
            endcase
        end

        // Bus read, data in the following cycle
        if (reg_rd) begin
            unique case (reg_addr)
                ltd_pkg::OFS_WORK: s_nxt.rdata = s_r.work;
                ltd_pkg::OFS_STATUS: s_nxt.rdata = {3'h0, s_r.status};
                ltd_pkg::OFS_BANK: s_nxt.rdata = {4'h0, s_r.bank};
                ltd_pkg::OFS_TP_L: s_nxt.rdata = s_r.tptr[7:0];
                ltd_pkg::OFS_TP_H: s_nxt.rdata = s_r.tptr[15:8];
                ltd_pkg::OFS_TP_U: s_nxt.rdata = {3'h0, s_r.tptr[20:16]};
                ltd_pkg::OFS_LATCH: s_nxt.rdata = s_r.latch;
                ltd_pkg::OFS_PROD_L: s_nxt.rdata = s_r.prod[7:0];
                ltd_pkg::OFS_PROD_H: s_nxt.rdata = s_r.prod[15:8];
                default: begin
                    s_nxt.rdata = 8'h00;
                    if (sel_idx < 5'(2 * ltd_pkg::FSP_N)) begin
                        s_nxt.rdata = sel_idx[0] ? {4'h0, s_r.fsp[sel_idx[4:1]][11:8]}
                                                 : s_r.fsp[sel_idx[4:1]][7:0];
                    end
                end
            endcase
        end

        unique case (s_r.phase)
            ltd_pkg::PH_RUN: begin
                if (pc_change) begin
                    s_nxt.phase = ltd_pkg::PH_NOP2;
                end else if (instr_valid) begin
                    if (op_hi == ltd_pkg::OP_ADD) begin
                        sum = {1'b0, s_r.work} + {1'b0, lit};
                        nib = {1'b0, s_r.work[3:0]} + {1'b0, lit[3:0]};
                        s_nxt.work = sum[7:0];
                        s_nxt.status[ltd_pkg::ST_C] = sum[8];
                        s_nxt.status[ltd_pkg::ST_DC] = nib[4];
                        s_nxt.status[ltd_pkg::ST_Z] = (sum[7:0] == 8'h00);
                        s_nxt.status[ltd_pkg::ST_OV] =
                            (s_r.work[7] == lit[7]) && (sum[7] != lit[7]);
                        s_nxt.status[ltd_pkg::ST_N] = sum[7];
                    end else if (op_hi == ltd_pkg::OP_SUB) begin
                        sum = {1'b0, lit} + {1'b0, ~s_r.work} + 9'h001;
                        nib = {1'b0, lit[3:0]} + {1'b0, ~s_r.work[3:0]} + 5'h01;
                        s_nxt.work = sum[7:0];
                        s_nxt.status[ltd_pkg::ST_C] = sum[8];
                        s_nxt.status[ltd_pkg::ST_DC] = nib[4];
                        s_nxt.status[ltd_pkg::ST_Z] = (sum[7:0] == 8'h00);
                        s_nxt.status[ltd_pkg::ST_OV] =
                            (s_r.work[7] != lit[7]) && (sum[7] != lit[7]);
                        s_nxt.status[ltd_pkg::ST_N] = sum[7];
                    end else if (op_hi == ltd_pkg::OP_AND || op_hi == ltd_pkg::OP_OR
                                 || op_hi == ltd_pkg::OP_XOR) begin
                        if (op_hi == ltd_pkg::OP_AND) begin
                            logic_res = s_r.work & lit;
                        end else if (op_hi == ltd_pkg::OP_OR) begin
                            logic_res = s_r.work | lit;
                        end else begin
                            logic_res = s_r.work ^ lit;
                        end
                        s_nxt.work = logic_res;
                        s_nxt.status[ltd_pkg::ST_Z] = (logic_res == 8'h00);
                        s_nxt.status[ltd_pkg::ST_N] = logic_res[7];
                    end else if (op_hi == ltd_pkg::OP_LOAD) begin
                        s_nxt.work = lit;
                    end else if (op_hi == ltd_pkg::OP_MUL) begin
                        s_nxt.prod = s_r.work * lit;
                    end else if (instr_word[15:4] == ltd_pkg::OP_BANK) begin
                        s_nxt.bank = instr_word[3:0];
                    end else if (op_hi == ltd_pkg::OP_RET) begin
                        s_nxt.work = lit;
                        s_nxt.ret_pop = 1'b1;
                        s_nxt.phase = ltd_pkg::PH_NOP2;
                    end else if (instr_word[15:6] == ltd_pkg::OP_PTR1) begin
                        s_nxt.fsp_sel = instr_word[5:4];
                        s_nxt.fsp_hi = instr_word[3:0];
                        s_nxt.phase = ltd_pkg::PH_PTR2;
                    end else if (instr_word[15:3] == ltd_pkg::OP_TBL) begin
                        // Whole pointer goes out as the byte address in memory
                        s_nxt.pm_addr = (instr_word[1:0] == ltd_pkg::TM_PRE_INC)
                                        ? tp_inc : s_r.tptr;
                        unique case (instr_word[1:0])
                            ltd_pkg::TM_NONE: s_nxt.tptr = s_r.tptr;
                            ltd_pkg::TM_POST_INC: s_nxt.tptr = tp_inc;
                            ltd_pkg::TM_POST_DEC: s_nxt.tptr = tp_dec;
                            ltd_pkg::TM_PRE_INC: s_nxt.tptr = tp_inc;
                        endcase
                        if (instr_word[2]) begin
                            s_nxt.pm_wr = 1'b1;
                            s_nxt.pm_wdata = s_r.latch;
                            s_nxt.phase = ltd_pkg::PH_NOP2;
                        end else begin
                            s_nxt.pm_rd = 1'b1;
                            s_nxt.phase = ltd_pkg::PH_TBL2;
                        end
                    end else if (op_hi[7:4] == ltd_pkg::OP_SECOND) begin
                        s_nxt.work = s_r.work;
                    end
                end
            end
            ltd_pkg::PH_PTR2: begin
                if (instr_valid) begin
                    if (op_hi == ltd_pkg::OP_PTR2
                        && s_r.fsp_sel < 2'(ltd_pkg::FSP_N)) begin
                        s_nxt.fsp[s_r.fsp_sel] = {s_r.fsp_hi, lit};
                    end
                    s_nxt.phase = ltd_pkg::PH_RUN;
                end
            end
            ltd_pkg::PH_TBL2: begin
                s_nxt.latch = pm_rdata;
                s_nxt.phase = ltd_pkg::PH_RUN;
            end
            ltd_pkg::PH_NOP2: begin
                s_nxt.phase = ltd_pkg::PH_RUN;
            end
        endcase
        s_nxt.busy = (s_nxt.phase != ltd_pkg::PH_RUN);
    end

    ////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Outputs
    assign reg_rdata_r = s_r.rdata;
    assign busy_r = s_r.busy;
    assign pm_rd_r = s_r.pm_rd;
    assign pm_wr_r = s_r.pm_wr;
    assign pm_addr_r = s_r.pm_addr;
    assign pm_wdata_r = s_r.pm_wdata;
    assign ret_pop_r = s_r.ret_pop;
    assign presc_clr_r = s_r.presc_clr;
    assign rmw_operand_r = s_r.rmw_operand;
    assign work_r = s_r.work;
    assign status_r = s_r.status;
    assign bank_r = s_r.bank;
    assign tptr_r = s_r.tptr;
    assign latch_r = s_r.latch;
endmodule : ltd_decoder

// >>> design/ltd_pkg.sv
// Function
// - High byte 0000_1111: work register plus literal, set C, DC, Z, OV, N
// - High byte 0000_1011: AND literal into work register, only Z and N change
// - High byte 0000_1001: OR literal into work register, only Z and N change
// - High byte 0000_1010: XOR literal into work register, only Z and N change
// - High byte 0000_1000: literal minus work register, all five flags updated
// - High byte 0000_1110: load literal into work register, no flags
// - High byte 0000_1101: literal times work register into product, no flags
// - Word 0000_0001_0000_kkkk: literal into low nibble of bank select, no flags
// - High byte 0000_1100: return from subroutine, literal into work, two cycles
// - Two-word 12-bit load of a file select pointer, two cycles, no flags
// - Table reads 0000_0000_0000_10nn: none, post-inc, post-dec, pre-inc; two cycles
// - Table writes 0000_0000_0000_11nn: same pointer modes; two cycles, no flags
// - Table read copies addressed byte to latch; pre-inc before, post after
// - Port modified from itself uses sensed pin levels, not the latch
// - Write to timer zero count clears prescaler when it is assigned there
// - Program counter change or true test takes two cycles, second a no-op
// - Lone second word of a two-word instruction executes as a no-op
// - Table pointer is 21 bits, a byte address over two megabytes
// - Whole pointer is the byte address; bit zero is an ordinary address bit
package ltd_pkg;
    localparam int TP_W = 21;
    localparam int FSP_N = 3;

    // Register map
    localparam logic [3:0] OFS_WORK = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h1;
    localparam logic [3:0] OFS_BANK = 4'h2;
    localparam logic [3:0] OFS_TP_L = 4'h3;
    localparam logic [3:0] OFS_TP_H = 4'h4;
    localparam logic [3:0] OFS_TP_U = 4'h5;
    localparam logic [3:0] OFS_LATCH = 4'h6;
    localparam logic [3:0] OFS_PROD_L = 4'h7;
    localparam logic [3:0] OFS_PROD_H = 4'h8;
    localparam logic [3:0] OFS_FSP_BASE = 4'h9;

    // Status bit positions
    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam int ST_OV = 3;
    localparam int ST_N = 4;

    // Opcodes matched on upper bits of the word
    localparam logic [7:0] OP_ADD = 8'h0f;
    localparam logic [7:0] OP_AND = 8'h0b;
    localparam logic [7:0] OP_OR = 8'h09;
    localparam logic [7:0] OP_XOR = 8'h0a;
    localparam logic [7:0] OP_SUB = 8'h08;
    localparam logic [7:0] OP_LOAD = 8'h0e;
    localparam logic [7:0] OP_MUL = 8'h0d;
    localparam logic [7:0] OP_RET = 8'h0c;
    localparam logic [11:0] OP_BANK = 12'h010;
    localparam logic [9:0] OP_PTR1 = 10'h3b8;
    localparam logic [7:0] OP_PTR2 = 8'hf0;
    localparam logic [3:0] OP_SECOND = 4'hf;
    localparam logic [12:0] OP_TBL = 13'h0001;

    // Table pointer modes
    localparam logic [1:0] TM_NONE = 2'h0;
    localparam logic [1:0] TM_POST_INC = 2'h1;
    localparam logic [1:0] TM_POST_DEC = 2'h2;
    localparam logic [1:0] TM_PRE_INC = 2'h3;

    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [TP_W-1:0] RST_TP = 21'h000000;

    typedef enum logic [1:0] {
        PH_RUN = 2'b00,
        PH_PTR2 = 2'b01,
        PH_TBL2 = 2'b10,
        PH_NOP2 = 2'b11
    } ltd_phase_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] data;
    } ltd_fsp_load_t;

    typedef struct packed {
        ltd_phase_t phase;
        logic busy;
        logic [7:0] work;
        logic [4:0] status;
        logic [3:0] bank;
        logic [TP_W-1:0] tptr;
        logic [7:0] latch;
        logic [15:0] prod;
        logic [FSP_N-1:0][11:0] fsp;
        logic [1:0] fsp_sel;
        logic [3:0] fsp_hi;
        logic pm_rd;
        logic pm_wr;
        logic [TP_W-1:0] pm_addr;
        logic [7:0] pm_wdata;
        logic [7:0] rdata;
        logic ret_pop;
        logic presc_clr;
        logic [7:0] rmw_operand;
        logic [7:0] pins_s1;
        logic [7:0] pins_s2;
    } ltd_state_t;
endpackage : ltd_pkg

// >>> test/ltd_pmem_model.sv
module ltd_pmem_model (
    input wire logic clk,
    input wire logic pm_rd_r,
    input wire logic pm_wr_r,
    input wire logic [20:0] pm_addr_r,
    input wire logic [7:0] pm_wdata_r,
    output logic [7:0] pm_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [256];
    logic [7:0] last_r = 8'h00;
    initial begin
        foreach (mem[i]) begin
            mem[i] = 8'(i) ^ 8'h5a;
        end
    end
    // Byte store, released bus shows inverse of last byte read
    assign pm_rdata = pm_rd_r ? mem[pm_addr_r[7:0]] : ~last_r;
    always @(posedge clk) begin
        if (pm_wr_r) begin
            mem[pm_addr_r[7:0]] <= pm_wdata_r;
        end
        if (pm_rd_r) begin
            last_r <= pm_rdata;
        end
    end
endmodule : ltd_pmem_model

// >>> test/ltd_decoder_sva.sv
module ltd_decoder_sva (
    input wire logic clk,
    input wire logic reset,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic pc_change,
    input wire logic [7:0] pm_rdata,
    input wire logic rmw_req,
    input wire logic rmw_src_is_port,
    input wire logic [7:0] port_pins,
    input wire logic [7:0] port_latch,
    input wire logic tz_write,
    input wire logic presc_assigned,
    input wire logic busy_r,
    input wire logic pm_rd_r,
    input wire logic pm_wr_r,
    input wire logic [7:0] pm_wdata_r,
    input wire logic ret_pop_r,
    input wire logic presc_clr_r,
    input wire logic [7:0] rmw_operand_r,
    input wire logic [7:0] work_r,
    input wire logic [4:0] status_r,
    input wire logic [7:0] latch_r
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic go;
    logic [7:0] op;
    assign go = instr_valid && !busy_r && !pc_change;
    assign op = instr_word[15:8];
    sequence s_done;
        busy_r ##1 !busy_r;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    AST_LOAD: assert property (go && op == ltd_pkg::OP_LOAD |=>
        work_r == $past(instr_word[7:0]) && $stable(status_r)) else $error("load wrong");
    AST_AND: assert property (go && op == ltd_pkg::OP_AND |=>
        work_r == ($past(instr_word[7:0]) & $past(work_r)) && status_r[2] == (work_r == 8'h00)
        && $stable(status_r[1:0]) && $stable(status_r[3])) else $error("and wrong");
    AST_RET: assert property (go && op == ltd_pkg::OP_RET |=>
        (ret_pop_r && work_r == $past(instr_word[7:0])) ##0 s_done) else $error("ret wrong");
    AST_TBL_RD: assert property (go && instr_word[15:2] == 14'h0002 |=>
        pm_rd_r ##0 s_done) else $error("table read wrong");
    AST_TBL_WR: assert property (go && instr_word[15:2] == 14'h0003 |=>
        (pm_wr_r && pm_wdata_r == $past(latch_r)) ##0 s_done) else $error("table write wrong");
    AST_LATCH: assert property (pm_rd_r |=> latch_r == $past(pm_rdata))
        else $error("latch wrong");
    AST_PRESC: assert property ($rose(tz_write) |=>
        presc_clr_r == $past(presc_assigned)) else $error("prescaler clear wrong");
    AST_RMW: assert property (rmw_req |=> rmw_operand_r ==
        ($past(rmw_src_is_port) ? $past(port_pins, 3) : $past(port_latch)))
        else $error("rmw wrong");
    AST_PC_NOP: assert property (instr_valid && pc_change && !busy_r |=>
        $stable(work_r) && $stable(status_r)) else $error("pc change not a no-op");
    AST_LONE: assert property (go && instr_word[15:12] == 4'hf |=>
        $stable(work_r) && !busy_r) else $error("lone second word acted");
endmodule : ltd_decoder_sva

// >>> test/ltd_decoder_bench.sv
module ltd_decoder_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic instr_valid = 1'b0, pc_change = 1'b0, rmw_req = 1'b0, rmw_src_is_port = 1'b0;
    logic tz_write = 1'b0, presc_assigned = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic [7:0] port_pins = 8'hc3, port_latch = 8'h3c, reg_wdata = 8'h00;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] pm_rdata, reg_rdata_r, pm_wdata_r, rmw_operand_r, work_r, latch_r;
    logic busy_r, pm_rd_r, pm_wr_r, ret_pop_r, presc_clr_r;
    logic [20:0] pm_addr_r, tptr_r, p, a, n;
    logic [4:0] status_r;
    logic [3:0] bank_r;
    logic [15:0] ops [9] = '{16'h0e3c, 16'h0b0f, 16'h0981, 16'h0a8d, 16'h0fff, 16'h0f01,
        16'h0880, 16'h087f, 16'h0c77};
    logic [15:0] res [9] = '{16'h003c, 16'h000c, 16'h108d, 16'h0400, 16'h10ff, 16'h0700,
        16'h1380, 16'h1aff, 16'h1a77};
    int err_total = 0;
    int samples_checked = 0;
    ltd_decoder ltd_decoder_i (.*);
    ltd_pmem_model ltd_pmem_model_i (.*);
    always #4 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("compares %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic exec(logic [15:0] w, logic pc = 1'b0);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_word <= w;
        pc_change <= pc;
        @(posedge clk);
        instr_valid <= 1'b0;
        pc_change <= 1'b0;
        #1;
        for (int i = 0; i < 4 && busy_r === 1'b1 && w[15:12] != 4'he; i++) begin
            @(posedge clk);
            #1;
        end
    endtask : exec
    task automatic bus(logic wr, logic [3:0] ad, logic [7:0] d);
        @(posedge clk);
        reg_wr <= wr;
        reg_rd <= !wr;
        reg_addr <= ad;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
    endtask : bus
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            exec(ops[i]);
            if (i < 4) begin
                chk("work", work_r, res[i][7:0]);
                chk("status", status_r, res[i][12:8]);
            end else begin
                chk("work", work_r, res[i][7:0]);
                chk("status", status_r, res[i][12:8]);
            end
        end
        bus(1'b0, ltd_pkg::OFS_WORK, 8'h00);
        chk("work_bus", reg_rdata_r, 8'h77);
        bus(1'b1, ltd_pkg::OFS_WORK, 8'h12);
        exec(16'h0d10);
        bus(1'b0, ltd_pkg::OFS_PROD_L, 8'h00);
        chk("prod_l", reg_rdata_r, 8'h20);
        bus(1'b0, ltd_pkg::OFS_PROD_H, 8'h00);
        chk("prod_h", reg_rdata_r, 8'h01);
        chk("mul_st", status_r, 5'h1a);
        exec(16'h0e55, 1'b1);
        chk("pc_nop", work_r, 8'h12);
        exec(16'hf0e5);
        chk("lone", work_r, 8'h12);
        exec(16'h0105);
        chk("bank", bank_r, 4'h5);
        exec(16'hee15);
        exec(16'hf0ab);
        bus(1'b0, ltd_pkg::OFS_FSP_BASE + 4'h2, 8'h00);
        chk("fsp_lo", reg_rdata_r, 8'hab);
        bus(1'b0, ltd_pkg::OFS_FSP_BASE + 4'h3, 8'h00);
        chk("fsp_hi", reg_rdata_r, 8'h05);
        bus(1'b1, 4'hf, 8'haa);
        bus(1'b0, 4'hf, 8'h00);
        chk("unmapped", reg_rdata_r, 8'h00);
        bus(1'b1, ltd_pkg::OFS_TP_L, 8'hff);
        bus(1'b1, ltd_pkg::OFS_TP_H, 8'hff);
        bus(1'b1, ltd_pkg::OFS_TP_U, 8'h1f);
        p = 21'h1fffff;
        for (int k = 0; k < 8; k++) begin
            a = (k[1:0] == 2'h3) ? p + 21'h000001 : p;
            n = (k[1:0] == 2'h2) ? p - 21'h000001 : ((k[1:0] == 2'h0) ? p : p + 21'h000001);
            exec(16'h0008 + 16'(k));
            chk("tbl_addr", pm_addr_r, a);
            chk("tbl_ptr", tptr_r, n);
            if (k < 4) begin
                chk("tbl_latch", latch_r, a[7:0] ^ 8'h5a);
            end
            p = n;
        end
        // Written byte must come back through a later table read
        bus(1'b1, ltd_pkg::OFS_LATCH, 8'h9e);
        exec(16'h000c);
        bus(1'b1, ltd_pkg::OFS_LATCH, 8'h00);
        exec(16'h0008);
        chk("tbl_wr_back", latch_r, 8'h9e);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            tz_write <= 1'b1;
            presc_assigned <= k[0];
            rmw_req <= 1'b1;
            rmw_src_is_port <= k[0];
            @(posedge clk);
            tz_write <= 1'b0;
            rmw_req <= 1'b0;
            #1;
            chk("presc", presc_clr_r, k[0]);
            chk("rmw", rmw_operand_r, k[0] ? 8'hc3 : 8'h3c);
        end
        summarize();
    end
    initial begin
        #40000;
        err_total++;
        summarize();
    end
endmodule : ltd_decoder_bench

bind ltd_decoder ltd_decoder_sva ltd_decoder_sva_i (.*);
